// ==== rtl/clock_speed_pkg.sv ====
`default_nettype none

package clock_speed_pkg;

    // Register port addresses
    localparam logic [7:0] SPEED_REG_ADDR     = 8'h8F;
    localparam logic [7:0] AUX_REG_ADDR       = 8'hA2;
    localparam logic [7:0] PTR_LOW_REG_ADDR   = 8'h82;
    localparam logic [7:0] PTR_HIGH_REG_ADDR  = 8'h83;

    // Field positions
    localparam int unsigned SPEED_SEL_BIT     = 0;
    localparam int unsigned PTR_SEL_BIT       = 0;
    localparam int unsigned STUCK_ZERO_BIT    = 2;
    localparam int unsigned USER_FLAG_BIT     = 3;

    // Reset values
    localparam logic        SPEED_SEL_RESET   = 1'b0;
    localparam logic        PTR_SEL_RESET     = 1'b0;
    localparam logic        USER_FLAG_RESET   = 1'b0;
    localparam logic [15:0] PTR_RESET         = 16'h0000;
    localparam logic [7:0]  READ_IDLE_VALUE   = 8'h00;

    // Oscillator periods per machine cycle
    localparam logic [3:0]  SLOW_PERIODS      = 4'hC;
    localparam logic [3:0]  FAST_PERIODS      = 4'h6;

    // Pointer operations from the core
    typedef enum logic [1:0] {
        PTR_NOP       = 2'h0,
        PTR_LOAD_LOW  = 2'h1,
        PTR_LOAD_HIGH = 2'h2,
        PTR_INC       = 2'h3
    } ptr_op_e;

endpackage : clock_speed_pkg

`default_nettype wire

// ==== rtl/speed_timebase.sv ====
`timescale 1ns/100ps
`default_nettype none

module speed_timebase (
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic doubleSpeedSelect,
    output logic      coreTick,
    output logic      machineTick,
    output logic      twelvePeriodMode
);

    typedef struct packed {
        logic [3:0] phase;
        logic       doubleMode;
        logic       coreTick;
        logic       machineTick;
    } state_s;

    state_s st;
    state_s next_st;
    logic [3:0] lastPhase;

    assign lastPhase = (st.doubleMode ? clock_speed_pkg::FAST_PERIODS
                                      : clock_speed_pkg::SLOW_PERIODS) - 4'h1;

    always_comb begin
        next_st = st;
        next_st.machineTick = (st.phase == lastPhase);
        // Core clock is crystal/2 in standard mode, crystal in double mode
        next_st.coreTick = st.doubleMode | st.phase[0];
        if (st.phase == lastPhase) begin
            next_st.phase = 4'h0;
            // Mode only changes on a machine cycle edge: no torn cycles
            next_st.doubleMode = doubleSpeedSelect;
        end else begin
            next_st.phase = st.phase + 4'h1;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign coreTick         = st.coreTick;
    assign machineTick      = st.machineTick;
    assign twelvePeriodMode = !st.doubleMode;

    property p_slow_cycle;
        @(posedge mclk) disable iff (!nrst)
        (machineTick && twelvePeriodMode) |-> ##12 machineTick;
    endproperty
    a_slow_cycle: assert property (p_slow_cycle) else $error("standard cycle not 12");

    property p_fast_cycle;
        @(posedge mclk) disable iff (!nrst)
        (machineTick && !twelvePeriodMode) |-> ##1 !machineTick [*5] ##1 machineTick;
    endproperty
    a_fast_cycle: assert property (p_fast_cycle) else $error("double cycle not 6");

    property p_core_half;
        @(posedge mclk) disable iff (!nrst)
        (twelvePeriodMode && coreTick) |=> !coreTick;
    endproperty
    a_core_half: assert property (p_core_half) else $error("core tick too fast");

endmodule : speed_timebase

`default_nettype wire

// ==== rtl/clock_speed_and_pointer_select.sv ====
// Functional notes
// - Speed bit switches 12/6 periods, both ways
// - Reset starts in standard speed
// - Double speed halves peripheral timing reference
// - Speed bit zero: 12 periods, crystal/2
// - Speed bit one: 6 periods, crystal clock
// - Speed register resets bit 0 clear
// - Two independent 16-bit data pointers
// - Aux bit 0 selects the pointer
// - Select zero first pointer, one second
// - Aux bit 3 is free user flag
// - Aux resets bits 3,2,0; bit 2 zero
// - Reserved bits read back undefined; here they read zero
// - Reserved bits default zero, active one
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module clock_speed_and_pointer_select (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [7:0]  regRdData,
    input  wire logic [1:0]  ptrOp,
    input  wire logic [7:0]  ptrByte,
    output logic      [15:0] activePointer,
    output logic      [15:0] firstDataPointer,
    output logic      [15:0] secondDataPointer,
    output logic             pointerSelect,
    output logic             userFlag,
    output logic             doubleSpeedSelect,
    output logic             twelvePeriodMode,
    output logic             coreTick,
    output logic             timeRefTick,
    output logic             machineTick
);

    typedef struct packed {
        logic        speedSel;
        logic        ptrSel;
        logic        userFlag;
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        logic [7:0]  rdData;
    } state_s;

    localparam state_s RESET_STATE = '{
        speedSel: clock_speed_pkg::SPEED_SEL_RESET,
        ptrSel:   clock_speed_pkg::PTR_SEL_RESET,
        userFlag: clock_speed_pkg::USER_FLAG_RESET,
        ptr0:     clock_speed_pkg::PTR_RESET,
        ptr1:     clock_speed_pkg::PTR_RESET,
        rdData:   clock_speed_pkg::READ_IDLE_VALUE
    };

    state_s st;
    state_s next_st;
    logic [15:0] selPtr;
    logic [15:0] newPtr;
    logic        coreTickRaw;

    assign selPtr = st.ptrSel ? st.ptr1 : st.ptr0;

    // Core pointer op first, then a register-port byte write of the same
    // pointer overrides it; both act on the pointer chosen before this edge.
    always_comb begin
        newPtr = selPtr;
        case (clock_speed_pkg::ptr_op_e'(ptrOp))
            clock_speed_pkg::PTR_LOAD_LOW: begin
                newPtr[7:0] = ptrByte;
            end
            clock_speed_pkg::PTR_LOAD_HIGH: begin
                newPtr[15:8] = ptrByte;
            end
            clock_speed_pkg::PTR_INC: begin
                newPtr = selPtr + 16'h0001;
            end
            default: begin
                newPtr = selPtr;
            end
        endcase
        if (regWr && regAddr == clock_speed_pkg::PTR_LOW_REG_ADDR) begin
            newPtr[7:0] = regWrData;
        end
        if (regWr && regAddr == clock_speed_pkg::PTR_HIGH_REG_ADDR) begin
            newPtr[15:8] = regWrData;
        end
    end

    always_comb begin
        next_st = st;
        next_st.rdData = clock_speed_pkg::READ_IDLE_VALUE;

        // Only the selected pointer moves; the other keeps its value
        if (st.ptrSel) begin
            next_st.ptr1 = newPtr;
        end else begin
            next_st.ptr0 = newPtr;
        end

        if (regWr) begin
            case (regAddr)
                clock_speed_pkg::SPEED_REG_ADDR: begin
                    // Reserved bits are not stored
                    next_st.speedSel = regWrData[clock_speed_pkg::SPEED_SEL_BIT];
                end
                clock_speed_pkg::AUX_REG_ADDR: begin
                    next_st.ptrSel   = regWrData[clock_speed_pkg::PTR_SEL_BIT];
                    next_st.userFlag = regWrData[clock_speed_pkg::USER_FLAG_BIT];
                end
                default: begin
                    next_st.speedSel = st.speedSel;
                end
            endcase
        end

        // Reserved bits read as zero, the state a future feature resets to
        if (regRd) begin
            case (regAddr)
                clock_speed_pkg::SPEED_REG_ADDR: begin
                    next_st.rdData[clock_speed_pkg::SPEED_SEL_BIT] = st.speedSel;
                end
                clock_speed_pkg::AUX_REG_ADDR: begin
                    next_st.rdData[clock_speed_pkg::PTR_SEL_BIT]    = st.ptrSel;
                    next_st.rdData[clock_speed_pkg::USER_FLAG_BIT]  = st.userFlag;
                    next_st.rdData[clock_speed_pkg::STUCK_ZERO_BIT] = 1'b0;
                end
                clock_speed_pkg::PTR_LOW_REG_ADDR: begin
                    next_st.rdData = selPtr[7:0];
                end
                clock_speed_pkg::PTR_HIGH_REG_ADDR: begin
                    next_st.rdData = selPtr[15:8];
                end
                default: begin
                    next_st.rdData = clock_speed_pkg::READ_IDLE_VALUE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st <= RESET_STATE;
        end else begin
            st <= next_st;
        end
    end

    speed_timebase u_timebase (
        .mclk              (mclk),
        .nrst              (nrst),
        .doubleSpeedSelect (st.speedSel),
        .coreTick          (coreTickRaw),
        .machineTick       (machineTick),
        .twelvePeriodMode  (twelvePeriodMode)
    );

    // Peripherals time off the core tick, so double speed halves their base
    assign timeRefTick = coreTickRaw;
    assign coreTick    = coreTickRaw;

    assign regRdData         = st.rdData;
    assign activePointer     = selPtr;
    assign firstDataPointer  = st.ptr0;
    assign secondDataPointer = st.ptr1;
    assign pointerSelect     = st.ptrSel;
    assign userFlag          = st.userFlag;
    assign doubleSpeedSelect = st.speedSel;

    property p_speed_write;
        @(posedge mclk) disable iff (!nrst)
        (regWr && regAddr == clock_speed_pkg::SPEED_REG_ADDR)
            |=> doubleSpeedSelect == $past(regWrData[0]);
    endproperty
    a_speed_write: assert property (p_speed_write) else $error("speed bit not written");

    property p_enter_slow;
        @(posedge mclk) disable iff (!nrst)
        $fell(doubleSpeedSelect) |-> ##[0:13] twelvePeriodMode;
    endproperty
    a_enter_slow: assert property (p_enter_slow) else $error("standard mode not entered");

    property p_enter_fast;
        @(posedge mclk) disable iff (!nrst)
        $rose(doubleSpeedSelect) |-> ##[0:13] !twelvePeriodMode;
    endproperty
    a_enter_fast: assert property (p_enter_fast) else $error("double mode not entered");

    property p_time_ref;
        @(posedge mclk) disable iff (!nrst)
        !twelvePeriodMode |=> timeRefTick;
    endproperty
    a_time_ref: assert property (p_time_ref) else $error("time reference not doubled");

    property p_speed_read;
        @(posedge mclk) disable iff (!nrst)
        (regRd && regAddr == clock_speed_pkg::SPEED_REG_ADDR)
            |=> regRdData == {7'h00, $past(doubleSpeedSelect)};
    endproperty
    a_speed_read: assert property (p_speed_read) else $error("speed read wrong");

    property p_aux_read;
        @(posedge mclk) disable iff (!nrst)
        (regRd && regAddr == clock_speed_pkg::AUX_REG_ADDR)
            |=> regRdData == {4'h0, $past(userFlag), 2'b00, $past(pointerSelect)};
    endproperty
    a_aux_read: assert property (p_aux_read) else $error("aux read wrong");

    property p_aux_write;
        @(posedge mclk) disable iff (!nrst)
        (regWr && regAddr == clock_speed_pkg::AUX_REG_ADDR)
            |=> pointerSelect == $past(regWrData[0]) && userFlag == $past(regWrData[3])
                && doubleSpeedSelect == $past(doubleSpeedSelect);
    endproperty
    a_aux_write: assert property (p_aux_write) else $error("aux write wrong");

    property p_inc_first;
        @(posedge mclk) disable iff (!nrst)
        (ptrOp == 2'b11 && !pointerSelect && !regWr)
            |=> firstDataPointer == $past(firstDataPointer) + 16'h0001
                && secondDataPointer == $past(secondDataPointer);
    endproperty
    a_inc_first: assert property (p_inc_first) else $error("first pointer inc wrong");

    property p_inc_second;
        @(posedge mclk) disable iff (!nrst)
        (ptrOp == 2'b11 && pointerSelect && !regWr)
            |=> secondDataPointer == $past(secondDataPointer) + 16'h0001
                && firstDataPointer == $past(firstDataPointer);
    endproperty
    a_inc_second: assert property (p_inc_second) else $error("second pointer inc wrong");

    property p_unmapped;
        @(posedge mclk) disable iff (!nrst)
        (regRd && regAddr != clock_speed_pkg::SPEED_REG_ADDR
               && regAddr != clock_speed_pkg::AUX_REG_ADDR
               && regAddr != clock_speed_pkg::PTR_LOW_REG_ADDR
               && regAddr != clock_speed_pkg::PTR_HIGH_REG_ADDR)
            |=> regRdData == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_speed_hold;
        @(posedge mclk) disable iff (!nrst)
        !(regWr && regAddr == clock_speed_pkg::SPEED_REG_ADDR)
            |=> $stable(doubleSpeedSelect);
    endproperty
    a_speed_hold: assert property (p_speed_hold) else $error("speed bit moved");

    property p_aux_hold;
        @(posedge mclk) disable iff (!nrst)
        !(regWr && regAddr == clock_speed_pkg::AUX_REG_ADDR)
            |=> $stable(pointerSelect) && $stable(userFlag);
    endproperty
    a_aux_hold: assert property (p_aux_hold) else $error("aux bits moved");

    property p_mode_change;
        @(posedge mclk) disable iff (!nrst)
        $changed(twelvePeriodMode) |-> machineTick;
    endproperty
    a_mode_change: assert property (p_mode_change) else $error("mode changed mid cycle");

    property p_mode_follow;
        @(posedge mclk) disable iff (!nrst)
        machineTick |-> twelvePeriodMode == !$past(doubleSpeedSelect);
    endproperty
    a_mode_follow: assert property (p_mode_follow) else $error("mode not from speed bit");

    property p_keep_first;
        @(posedge mclk) disable iff (!nrst)
        pointerSelect |=> $stable(firstDataPointer);
    endproperty
    a_keep_first: assert property (p_keep_first) else $error("idle first pointer moved");

    property p_keep_second;
        @(posedge mclk) disable iff (!nrst)
        !pointerSelect |=> $stable(secondDataPointer);
    endproperty
    a_keep_second: assert property (p_keep_second) else $error("idle second pointer moved");

    property p_load_low;
        @(posedge mclk) disable iff (!nrst)
        (ptrOp == clock_speed_pkg::PTR_LOAD_LOW && !regWr)
            |=> activePointer == {$past(activePointer[15:8]), $past(ptrByte)};
    endproperty
    a_load_low: assert property (p_load_low) else $error("low byte load wrong");

    property p_load_high;
        @(posedge mclk) disable iff (!nrst)
        (ptrOp == clock_speed_pkg::PTR_LOAD_HIGH && !regWr)
            |=> activePointer == {$past(ptrByte), $past(activePointer[7:0])};
    endproperty
    a_load_high: assert property (p_load_high) else $error("high byte load wrong");

    property p_port_low;
        @(posedge mclk) disable iff (!nrst)
        (regWr && regAddr == clock_speed_pkg::PTR_LOW_REG_ADDR)
            |=> activePointer[7:0] == $past(regWrData);
    endproperty
    a_port_low: assert property (p_port_low) else $error("low byte write wrong");

    property p_port_high;
        @(posedge mclk) disable iff (!nrst)
        (regWr && regAddr == clock_speed_pkg::PTR_HIGH_REG_ADDR)
            |=> activePointer[15:8] == $past(regWrData);
    endproperty
    a_port_high: assert property (p_port_high) else $error("high byte write wrong");

    property p_read_low;
        @(posedge mclk) disable iff (!nrst)
        (regRd && regAddr == clock_speed_pkg::PTR_LOW_REG_ADDR)
            |=> regRdData == $past(activePointer[7:0]);
    endproperty
    a_read_low: assert property (p_read_low) else $error("low byte read wrong");

    property p_read_high;
        @(posedge mclk) disable iff (!nrst)
        (regRd && regAddr == clock_speed_pkg::PTR_HIGH_REG_ADDR)
            |=> regRdData == $past(activePointer[15:8]);
    endproperty
    a_read_high: assert property (p_read_high) else $error("high byte read wrong");

    property p_read_idle;
        @(posedge mclk) disable iff (!nrst)
        !regRd |=> regRdData == clock_speed_pkg::READ_IDLE_VALUE;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data outside slot");

    property p_inc_wrap;
        @(posedge mclk) disable iff (!nrst)
        (ptrOp == clock_speed_pkg::PTR_INC && !regWr && activePointer == 16'hFFFF)
            |=> activePointer == 16'h0000;
    endproperty
    a_inc_wrap: assert property (p_inc_wrap) else $error("pointer did not wrap");

    property p_fast_core;
        @(posedge mclk) disable iff (!nrst)
        !twelvePeriodMode |-> coreTick;
    endproperty
    a_fast_core: assert property (p_fast_core) else $error("core tick gap in double mode");

endmodule : clock_speed_and_pointer_select

`default_nettype wire

// ==== verification/cpu_sfr_master.sv ====
`timescale 1ns/100ps
`default_nettype none

module cpu_sfr_master (
    input  wire logic       mclk,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWrData,
    output logic            regWr,
    output logic            regRd,
    input  wire logic [7:0] regRdData,
    output logic      [1:0] ptrOp,
    output logic      [7:0] ptrByte
);
    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        ptrOp = 2'h0;
        ptrByte = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        // Software keeps reserved bits at zero
        regWrData <= (a == 8'h8F) ? (d & 8'h01) : (a == 8'hA2) ? (d & 8'h09) : d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        regAddr <= ~a;
        #1 d = regRdData;
    endtask : rd

    task automatic ptr(input clock_speed_pkg::ptr_op_e op, input logic [7:0] b);
        @(posedge mclk);
        ptrOp <= op;
        ptrByte <= b;
        @(posedge mclk);
        ptrOp <= 2'h0;
        ptrByte <= ~b;
        #1;
    endtask : ptr
endmodule : cpu_sfr_master

`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb;
    localparam logic [7:0] SPD = clock_speed_pkg::SPEED_REG_ADDR;
    localparam logic [7:0] AUX = clock_speed_pkg::AUX_REG_ADDR;
    logic        mclk;
    logic        nrst;
    logic [7:0]  regAddr;
    logic [7:0]  regWrData;
    logic        regWr;
    logic        regRd;
    logic [7:0]  regRdData;
    logic [1:0]  ptrOp;
    logic [7:0]  ptrByte;
    logic [15:0] activePointer;
    logic [15:0] firstDataPointer;
    logic [15:0] secondDataPointer;
    logic        pointerSelect;
    logic        userFlag;
    logic        doubleSpeedSelect;
    logic        twelvePeriodMode;
    logic        coreTick;
    logic        timeRefTick;
    logic        machineTick;
    logic [7:0]  rdata;
    int          error_cnt;
    int          check_count;

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    cpu_sfr_master cpu_u (.mclk(mclk), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .ptrOp(ptrOp),
        .ptrByte(ptrByte));

    clock_speed_and_pointer_select dut_u (.mclk(mclk), .nrst(nrst),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .ptrOp(ptrOp), .ptrByte(ptrByte),
        .activePointer(activePointer), .firstDataPointer(firstDataPointer),
        .secondDataPointer(secondDataPointer), .pointerSelect(pointerSelect),
        .userFlag(userFlag), .doubleSpeedSelect(doubleSpeedSelect),
        .twelvePeriodMode(twelvePeriodMode), .coreTick(coreTick),
        .timeRefTick(timeRefTick), .machineTick(machineTick));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic step;
        @(posedge mclk);
        #1;
    endtask : step

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    task automatic tick_gap(output int n);
        n = 0;
        while (machineTick !== 1'b1 && n < 30) begin
            step();
            n++;
        end
        n = 0;
        do begin
            step();
            n++;
        end while (machineTick !== 1'b1 && n < 30);
    endtask : tick_gap

    // Machine cycle length and peripheral time reference for one mode
    task automatic mode_check(input logic dbl);
        int n;
        int k;
        int j;
        k = 0;
        j = 0;
        tick_gap(n);
        chk(16'(n), dbl ? 16'h0006 : 16'h000C);
        repeat (12) begin
            step();
            k += (coreTick === 1'b1) ? 1 : 0;
            j += (timeRefTick === 1'b1) ? 1 : 0;
            chk(16'(timeRefTick), 16'(coreTick));
        end
        chk(16'(k), dbl ? 16'h000C : 16'h0006);
        chk(16'(j), dbl ? 16'h000C : 16'h0006);
    endtask : mode_check

    task automatic wait_mode(input logic twelve);
        int n;
        n = 0;
        while (twelvePeriodMode !== twelve && n < 14) begin
            step();
            n++;
        end
        chk(16'(twelvePeriodMode), 16'(twelve));
    endtask : wait_mode

    task automatic t_reset;
        chk(16'(twelvePeriodMode), 16'h0001);
        chk(16'(doubleSpeedSelect), 16'h0000);
        cpu_u.rd(SPD, rdata);
        chk(16'(rdata[0]), 16'h0000);
        cpu_u.rd(AUX, rdata);
        chk(16'(rdata & 8'h0D), 16'h0000);
        cpu_u.rd(8'h55, rdata);
        chk(16'(rdata), 16'h0000);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_aux;
        cpu_u.wr(AUX, 8'h09);
        chk(16'(userFlag), 16'h0001);
        chk(16'(pointerSelect), 16'h0001);
        cpu_u.rd(AUX, rdata);
        chk(16'(rdata & 8'h0D), 16'h0009);
        step();
        chk(16'(regRdData), 16'h0000);
        cpu_u.wr(AUX, 8'h08);
        chk(16'(pointerSelect), 16'h0000);
        chk(16'(userFlag), 16'h0001);
        chk(16'(twelvePeriodMode), 16'h0001);
        $display("t_aux done");
    endtask : t_aux

    task automatic t_ptr;
        cpu_u.ptr(clock_speed_pkg::PTR_LOAD_LOW, 8'hFF);
        cpu_u.ptr(clock_speed_pkg::PTR_LOAD_HIGH, 8'hFF);
        chk(firstDataPointer, 16'hFFFF);
        chk(activePointer, 16'hFFFF);
        cpu_u.ptr(clock_speed_pkg::PTR_INC, 8'h00);
        chk(firstDataPointer, 16'h0000);
        chk(secondDataPointer, 16'h0000);
        cpu_u.wr(AUX, 8'h01);
        cpu_u.wr(clock_speed_pkg::PTR_LOW_REG_ADDR, 8'h34);
        cpu_u.wr(clock_speed_pkg::PTR_HIGH_REG_ADDR, 8'h12);
        cpu_u.ptr(clock_speed_pkg::PTR_INC, 8'h00);
        chk(secondDataPointer, 16'h1235);
        chk(firstDataPointer, 16'h0000);
        chk(activePointer, 16'h1235);
        cpu_u.rd(clock_speed_pkg::PTR_HIGH_REG_ADDR, rdata);
        chk(16'(rdata), 16'h0012);
        cpu_u.rd(clock_speed_pkg::PTR_LOW_REG_ADDR, rdata);
        chk(16'(rdata), 16'h0035);
        $display("t_ptr done");
    endtask : t_ptr

    task automatic t_speed;
        mode_check(1'b0);
        cpu_u.wr(SPD, 8'h01);
        chk(16'(doubleSpeedSelect), 16'h0001);
        wait_mode(1'b0);
        mode_check(1'b1);
        cpu_u.rd(SPD, rdata);
        chk(16'(rdata[0]), 16'h0001);
        cpu_u.wr(SPD, 8'h00);
        wait_mode(1'b1);
        mode_check(1'b0);
        cpu_u.wr(SPD, 8'h01);
        $display("t_speed done");
    endtask : t_speed

    // Second reset in mid-run must bring back standard speed
    task automatic t_rereset;
        int n;
        cpu_u.wr(AUX, 8'h09);
        @(posedge mclk);
        nrst <= 1'b0;
        step();
        chk(16'(doubleSpeedSelect), 16'h0000);
        chk(16'(userFlag), 16'h0000);
        chk(16'(pointerSelect), 16'h0000);
        chk(secondDataPointer, 16'h0000);
        @(posedge mclk);
        nrst <= 1'b1;
        n = 0;
        do begin
            step();
            n++;
        end while (machineTick !== 1'b1 && n < 30);
        chk(16'(n), 16'h000C);
        chk(16'(twelvePeriodMode), 16'h0001);
        $display("t_rereset done");
    endtask : t_rereset

    initial begin
        error_cnt = 0;
        check_count = 0;
        nrst = 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        step();
        t_reset();
        t_aux();
        t_ptr();
        t_speed();
        t_rereset();
        print_verdict();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        #(5000 * 100);
        error_cnt++;
        print_verdict();
    end
endmodule : tb

`default_nettype wire
